/* File: thlc_pkg.sv */
// Constants and state type for the hardware limit timer control slice
package thlc_pkg;
    // ------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CONTROL   = 3'h0;
    localparam logic [2:0] ADDR_HW_LIMIT  = 3'h1;
    localparam logic [2:0] ADDR_RST_SEL   = 3'h2;
    localparam logic [2:0] ADDR_PERIOD    = 3'h3;
    localparam logic [2:0] ADDR_COUNT     = 3'h4;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_ON_BIT    = 7;
    localparam int         HLT_PRESCALER_SYNC_EN_BIT  = 7;
    localparam int         HLT_CLOCK_EDGE_POLARITY_BIT  = 6;
    localparam int         HLT_CLOCK_SYNC_EN_BIT = 5;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [7:0] RESET_PERIOD   = 8'hFF;
    localparam logic [2:0] RST_SEL_PAD    = 3'h0;
    localparam logic [7:0] COUNT_ZERO     = 8'h00;
    localparam logic [7:0] COUNT_ONE      = 8'h01;

    // ------------------------------------------------------------
    // Mode codes and reset source codes
    // ------------------------------------------------------------
    localparam logic [4:0] MODE_EXT_RESET = 5'h01;
    localparam logic [4:0] MODE_ONE_SHOT  = 5'h08;
    localparam logic [4:0] RSEL_RESV_A    = 5'h1E;
    localparam logic [4:0] RSEL_RESV_B    = 5'h1F;
    localparam int         NUM_SOURCES    = 32;

    // ------------------------------------------------------------
    // Start delay in input-clock periods when sync is enabled
    // ------------------------------------------------------------
    localparam logic [1:0] START_DELAY    = 2'h2;
    localparam logic [1:0] DELAY_NONE     = 2'h0;
    localparam logic [1:0] DELAY_STEP     = 2'h1;

    typedef struct packed {
        logic       on;
        logic [2:0] prescale;
        logic [3:0] postscale;
        logic [7:0] hwLimit;
        logic [4:0] rstSel;
        logic [7:0] period;
        logic [7:0] count;
        logic       clkPrev;
        logic [1:0] startDelay;
        logic       running;
        logic [7:0] rdData;
        logic       match;
    } thlc_state_t;
endpackage

/* File: thlc_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module thlc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,      // System clock
    input  wire logic             reset,    // Synchronous reset
    input  wire logic             clkEn,    // Freezes state when low
    input  wire logic [WIDTH-1:0] asyncIn,  // Levels from outside the domain
    output logic      [WIDTH-1:0] syncOut   // Synchronised levels
);
    logic [WIDTH-1:0] stage1;

    // ------------------------------------------------------------
    // One two-stage chain per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (reset) begin
                    stage1[i]  <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else if (clkEn) begin
                    stage1[i]  <= asyncIn[i];
                    syncOut[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

/* File: thlc_timer.sv */
// Hardware limit timer control slice: registers, start control and count
//
// Notes on behaviour
// - Hardware clears enable in one-shot mode
// - Enable starts counting, disable freezes count
// - Count equal period clears at next tick
// - Five-bit reset source select in bits 4-0
// - Select bits 7-5 read zero, ignore writes
// - Code zero is pin, 11110/11111 reserved
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module thlc_timer
    import thlc_pkg::*;
(
    input  wire logic                   clk,          // System clock, 100 MHz
    input  wire logic                   reset,        // Synchronous reset, active high
    input  wire logic                   clkEn,        // Freezes all state while low
    input  wire logic [2:0]             addr,         // Register index
    input  wire logic [7:0]             wrData,       // Write data
    input  wire logic                   wrEn,         // Write strobe
    input  wire logic                   rdEn,         // Read strobe
    input  wire logic                   timerClkIn,   // Selected timer input clock
    input  wire logic [NUM_SOURCES-1:0] resetSources, // External reset candidates, bit 0 is pin
    output logic      [7:0]             rdData,       // Read data, cycle after strobe
    output logic      [7:0]             timerCount,   // Live count value
    output logic                        timerRunning, // Timer is counting
    output logic                        periodMatch   // Pulse on period rollover
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    thlc_state_t                s;
    thlc_state_t                next_s;
    logic [NUM_SOURCES:0]       syncIn;
    logic [NUM_SOURCES:0]       syncOut;
    logic                       clkSynced;
    logic [NUM_SOURCES-1:0]     srcSynced;
    logic                       tick;
    logic                       extResetActive;
    logic                       polarity;

    // Reserved codes select nothing
    function automatic logic pick_source(input logic [4:0] code,
                                         input logic [NUM_SOURCES-1:0] src);
        logic r;
        r = src[code];
        if (code == RSEL_RESV_A || code == RSEL_RESV_B) begin
            r = 1'b0;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    assign syncIn = {resetSources, timerClkIn};

    thlc_sync #(
        .WIDTH(NUM_SOURCES + 1)
    ) u_sync (
        .clk     (clk),
        .reset   (reset),
        .clkEn   (clkEn),
        .asyncIn (syncIn),
        .syncOut (syncOut)
    );

    assign clkSynced = syncOut[0];
    assign srcSynced = syncOut[NUM_SOURCES:1];
    assign polarity  = s.hwLimit[HLT_CLOCK_EDGE_POLARITY_BIT];

    // Edge chosen by polarity advances the timer
    assign tick = polarity ? (s.clkPrev & ~clkSynced)
                           : (~s.clkPrev & clkSynced);

    // Selected external reset, only in the reset mode
    assign extResetActive = (s.hwLimit[4:0] == MODE_EXT_RESET) &&
                            pick_source(s.rstSel, srcSynced);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s         = s;
        next_s.clkPrev = clkSynced;
        next_s.match   = 1'b0;
        next_s.rdData  = RESET_BYTE;

        // Start delay counts input-clock ticks
        if (tick && s.startDelay != DELAY_NONE) begin
            next_s.startDelay = s.startDelay - DELAY_STEP;
        end

        // Counting only while running; stopped count is held
        if (s.running && tick) begin
            if (s.count == s.period) begin
                next_s.count = COUNT_ZERO;
                next_s.match = 1'b1;
                if (s.hwLimit[4:0] == MODE_ONE_SHOT) begin
                    next_s.on = 1'b0;
                end
            end else if (extResetActive) begin
                next_s.count = COUNT_ZERO;
            end else begin
                next_s.count = s.count + COUNT_ONE;
            end
        end

        // Register writes; a software write beats a hardware clear
        if (wrEn) begin
            case (addr)
                ADDR_CONTROL: begin
                    next_s.on        = wrData[CTRL_ON_BIT];
                    next_s.prescale  = wrData[6:4];
                    next_s.postscale = wrData[3:0];
                    if (wrData[CTRL_ON_BIT] && !s.on) begin
                        next_s.startDelay = s.hwLimit[HLT_CLOCK_SYNC_EN_BIT] ? START_DELAY : DELAY_NONE;
                    end
                end
                ADDR_HW_LIMIT: begin
                    next_s.hwLimit = wrData;
                end
                ADDR_RST_SEL: begin
                    next_s.rstSel = wrData[4:0];
                end
                ADDR_PERIOD: begin
                    next_s.period = wrData;
                end
                default: begin
                end
            endcase
        end

        // Disable stops at once; enable waits for the delay
        next_s.running = next_s.on && (next_s.startDelay == DELAY_NONE);

        // Register reads
        if (rdEn) begin
            case (addr)
                ADDR_CONTROL:  next_s.rdData = {s.on, s.prescale, s.postscale};
                ADDR_HW_LIMIT: next_s.rdData = s.hwLimit;
                ADDR_RST_SEL:  next_s.rdData = {RST_SEL_PAD, s.rstSel};
                ADDR_PERIOD:   next_s.rdData = s.period;
                ADDR_COUNT:    next_s.rdData = s.count;
                default:       next_s.rdData = RESET_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            s.on         <= 1'b0;
            s.prescale   <= 3'h0;
            s.postscale  <= 4'h0;
            s.hwLimit    <= RESET_BYTE;
            s.rstSel     <= 5'h00;
            s.period     <= RESET_PERIOD;
            s.count      <= COUNT_ZERO;
            s.clkPrev    <= 1'b0;
            s.startDelay <= DELAY_NONE;
            s.running    <= 1'b0;
            s.rdData     <= RESET_BYTE;
            s.match      <= 1'b0;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    // Outputs straight from state flops
    assign rdData       = s.rdData;
    assign timerCount   = s.count;
    assign timerRunning = s.running;
    assign periodMatch  = s.match;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !clkEn);

    a_match_clear: assert property (s.running && tick && s.count == s.period && clkEn
                                    |=> s.count == COUNT_ZERO && s.match)
        else $error("count not cleared after period match");
    a_stop_hold: assert property (!s.running && clkEn |=> s.count == $past(s.count))
        else $error("count moved while stopped");
    a_delay_block: assert property (s.startDelay != DELAY_NONE |-> !s.running)
        else $error("running during start delay");
    a_delay_load: assert property (wrEn && addr == ADDR_CONTROL && wrData[CTRL_ON_BIT] && !s.on
                                   && s.hwLimit[HLT_CLOCK_SYNC_EN_BIT] && clkEn
                                   |=> s.startDelay == START_DELAY && !s.running)
        else $error("start delay not loaded");
    a_one_shot: assert property (s.running && tick && s.count == s.period && clkEn && !wrEn
                                 && s.hwLimit[4:0] == MODE_ONE_SHOT |=> !s.on && !s.running)
        else $error("one-shot did not clear enable");
    a_rsel_store: assert property (wrEn && addr == ADDR_RST_SEL && clkEn
                                   |=> s.rstSel == $past(wrData[4:0]))
        else $error("reset select not stored");
    a_rsel_upper: assert property (rdEn && addr == ADDR_RST_SEL && clkEn
                                   |=> rdData[7:5] == RST_SEL_PAD)
        else $error("reset select upper bits not zero");
    a_resv_source: assert property (s.rstSel == RSEL_RESV_A || s.rstSel == RSEL_RESV_B
                                    |-> !extResetActive)
        else $error("reserved source acted as reset");
    a_count_edge: assert property (clkEn && !$past(reset) && s.count != $past(s.count) |-> $past(tick))
        else $error("count moved without a selected edge");

    c_rollover: cover property (s.match);
    c_sync_start: cover property (s.startDelay == START_DELAY ##[1:40] s.running);
    c_ext_reset: cover property (s.running && tick && extResetActive);
endmodule

/* File: thlc_partner.sv */
// Model of the peripherals that feed the timer input clock and reset sources
`timescale 1ns/10ps
module thlc_partner
    import thlc_pkg::*;
(
    input  wire logic                   clk,          // System clock
    input  wire logic [4:0]             srcCode,      // Source held at a steady level
    input  wire logic                   srcLevel,     // Level of that source
    output logic                        timerClkIn,   // Timer input clock
    output logic      [NUM_SOURCES-1:0] resetSources  // Reset candidates
);
    // ------------------------------------------------------------
    // Sources
    // ------------------------------------------------------------
    // Unselected sources toggle each cycle so none passes for a steady level
    always @(posedge clk) begin
        for (int i = 0; i < NUM_SOURCES; i++) begin
            resetSources[i] <= (i == int'(srcCode)) ? srcLevel : ~resetSources[i];
        end
    end

    // One input clock edge; the level then stands still for five cycles
    task automatic edge_to(input logic lvl);
        @(posedge clk);
        timerClkIn <= lvl;
        repeat (5) @(posedge clk);
    endtask

    // Input clock idles low between bursts
    initial begin
        timerClkIn   = 1'h0;
        resetSources = '0;
    end
endmodule

/* File: thlc_timer_bench.sv */
// Self-checking bench for the hardware limit timer control slice
`timescale 1ns/10ps
module thlc_timer_bench import thlc_pkg::*;;
    logic       clk, reset, clkEn, wrEn, rdEn, srcLevel, timerClkIn, timerRunning, periodMatch, seenMatch;
    logic [2:0] addr;
    logic [4:0] srcCode;
    logic [7:0] wrData, rdData, timerCount, rdVal;
    logic [NUM_SOURCES-1:0] resetSources;
    int         n_errors, cmp_count;

    thlc_timer u_thlc_timer (.clk(clk), .reset(reset), .clkEn(clkEn), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .timerClkIn(timerClkIn), .resetSources(resetSources), .rdData(rdData),
        .timerCount(timerCount), .timerRunning(timerRunning), .periodMatch(periodMatch));
    thlc_partner u_thlc_partner (.clk(clk), .srcCode(srcCode), .srcLevel(srcLevel),
        .timerClkIn(timerClkIn), .resetSources(resetSources));

    // ------------------------------------------------------------
    // Clock, match catcher, helpers
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    always @(posedge clk) if (periodMatch === 1'h1) seenMatch <= 1'h1;

    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk1(input string name, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'h1;
        @(posedge clk);
        wrEn <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'h1;
        @(posedge clk);
        rdEn <= 1'h0;
        #1;
        rdVal = rdData;
    endtask
    // One input clock edge, then the count is compared
    task automatic step(input logic lvl, input logic [7:0] e);
        u_thlc_partner.edge_to(lvl);
        #1;
        chk8("timerCount", e, timerCount);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_select();
        for (int a = 0; a < 6; a++) begin
            rd(3'(a));
            chk8("reset read", (a == 3) ? RESET_PERIOD : RESET_BYTE, rdVal);
        end
        wr(ADDR_RST_SEL, 8'hFF);
        rd(ADDR_RST_SEL);
        chk8("rst sel", 8'h1F, rdVal);
    endtask
    task automatic t_count_stop();
        wr(ADDR_RST_SEL, 8'h00);
        wr(ADDR_PERIOD, 8'h02);
        wr(ADDR_CONTROL, 8'h80);
        step(1'h1, 8'h01);
        step(1'h0, 8'h01);
        step(1'h1, 8'h02);
        u_thlc_partner.edge_to(1'h0);
        seenMatch = 1'h0;
        step(1'h1, 8'h00);
        chk1("periodMatch", 1'h1, seenMatch);
        u_thlc_partner.edge_to(1'h0);
        step(1'h1, 8'h01);
        wr(ADDR_CONTROL, 8'h00);
        u_thlc_partner.edge_to(1'h0);
        step(1'h1, 8'h01);
        rd(ADDR_COUNT);
        chk8("count read", 8'h01, rdVal);
        u_thlc_partner.edge_to(1'h0);
    endtask
    task automatic t_polarity();
        wr(ADDR_HW_LIMIT, 8'h40);
        rd(ADDR_HW_LIMIT);
        chk8("hw limit", 8'h40, rdVal);
        wr(ADDR_CONTROL, 8'h80);
        step(1'h1, 8'h01);
        step(1'h0, 8'h02);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_HW_LIMIT, 8'h00);
    endtask
    task automatic t_sync_start();
        wr(ADDR_PERIOD, 8'h10);
        wr(ADDR_HW_LIMIT, 8'h20);
        wr(ADDR_CONTROL, 8'h80);
        chk1("running early", 1'h0, timerRunning);
        repeat (2) begin
            step(1'h1, 8'h02);
            u_thlc_partner.edge_to(1'h0);
        end
        chk1("running late", 1'h1, timerRunning);
        step(1'h1, 8'h03);
        u_thlc_partner.edge_to(1'h0);
        wr(ADDR_CONTROL, 8'h00);
    endtask
    task automatic t_one_shot();
        wr(ADDR_PERIOD, 8'h04);
        wr(ADDR_HW_LIMIT, {3'h0, MODE_ONE_SHOT});
        wr(ADDR_CONTROL, 8'h80);
        step(1'h1, 8'h04);
        u_thlc_partner.edge_to(1'h0);
        step(1'h1, 8'h00);
        rd(ADDR_CONTROL);
        chk8("control after shot", 8'h00, rdVal);
        chk1("running after shot", 1'h0, timerRunning);
        u_thlc_partner.edge_to(1'h0);
        step(1'h1, 8'h00);
        u_thlc_partner.edge_to(1'h0);
    endtask
    task automatic t_ext_reset();
        wr(ADDR_HW_LIMIT, {3'h0, MODE_EXT_RESET});
        wr(ADDR_RST_SEL, 8'h05);
        srcCode  <= 5'h05;
        srcLevel <= 1'h1;
        wr(ADDR_CONTROL, 8'h80);
        step(1'h1, 8'h00);
        u_thlc_partner.edge_to(1'h0);
        wr(ADDR_RST_SEL, {3'h0, RSEL_RESV_A});
        srcCode <= RSEL_RESV_A;
        step(1'h1, 8'h01);
        u_thlc_partner.edge_to(1'h0);
        wr(ADDR_RST_SEL, 8'h00);
        srcCode <= 5'h00;
        step(1'h1, 8'h00);
    endtask
    // Low selected source lets the count run, then freeze and a reset in mid-run
    task automatic t_freeze_reset();
        srcLevel <= 1'h0;
        u_thlc_partner.edge_to(1'h0);
        step(1'h1, 8'h01);
        @(posedge clk);
        clkEn <= 1'h0;
        wr(ADDR_PERIOD, 8'h01);
        u_thlc_partner.edge_to(1'h0);
        step(1'h1, 8'h01);
        chk1("running frozen", 1'h1, timerRunning);
        @(posedge clk);
        clkEn <= 1'h1;
        rd(ADDR_PERIOD);
        chk8("period frozen", 8'h04, rdVal);
        @(posedge clk);
        reset <= 1'h1;
        @(posedge clk);
        reset <= 1'h0;
        #1;
        chk8("count after reset", COUNT_ZERO, timerCount);
        chk1("running after reset", 1'h0, timerRunning);
        rd(ADDR_PERIOD);
        chk8("period after reset", RESET_PERIOD, rdVal);
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        {clk, wrEn, rdEn, srcLevel, seenMatch, addr, wrData, srcCode} = '0;
        {reset, clkEn} = 2'h3;
        n_errors  = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        t_reset_and_select();
        t_count_stop();
        t_polarity();
        t_sync_start();
        t_one_shot();
        t_ext_reset();
        t_freeze_reset();
        final_report();
    end
endmodule
